//--- logic/sbp_sram_port.sv
/*
  Device side of a separate read/write port burst memory with double data
  rate on both ports. Link logic runs on the true and complementary input
  clocks (rising edges only); a small core section on clk_i reports activity.
  Assumes the host keeps addresses and data synchronous to the link clocks.
*/
// Behaviour
// - read address taken on true clock rise, write address on complement
// - each address holds two words moved as one two-word burst
// - mode pin high: read data appear two link cycles after capture
// - mode pin low: read data appear one link cycle after capture
// - both ports move one word on each rising edge of each clock
// - only rising edges of the two input clocks are used
// - every synchronous input is captured in input registers
// - read data leave from output registers on the input clocks
// - writes commit to the array internally after capture
// - reads and writes run concurrently without delaying each other
// - valid flag marks the cycle carrying returned read data
// - echo strobe pair runs aligned with the read data
// - separate active low selects start reads and writes independently
// - read after write to same address returns newest data
// - link clock up to 333 MHz, 666 MHz transfers per port
module sbp_sram_port
  import sbp_pkg::*;
(
  // core clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // link clocks
  input  wire logic              k_clk_i,
  input  wire logic              k_clk_n_i,
  // address and selects
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              read_port_select_n_i,
  input  wire logic              write_port_select_n_i,
  input  wire logic [LANES-1:0]  byte_lane_write_select_n_i,
  // write data
  input  wire logic [WORD_W-1:0] write_data_i,
  // latency mode pin
  input  wire logic              pll_disable_pin_i,
  // read data and strobes
  output logic      [WORD_W-1:0] read_data_rise_o,
  output logic      [WORD_W-1:0] read_data_fall_o,
  output logic                   read_valid_flag_o,
  output logic                   echo_strobe_o,
  output logic                   echo_strobe_n_o,
  // core side activity
  output logic                   read_event_o,
  output logic                   write_event_o
);

  // ==========================================================================
  // link resets and mode

  logic rst_k_n;
  logic rst_kn_n;
  logic long_q;       // two-cycle latency selected

  sbp_sync2 #(.W(1), .RST(1'b0)) u_rst_k (
    .clk_i     (k_clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (1'b1),
    .q_o       (rst_k_n)
  );

  sbp_sync2 #(.W(1), .RST(1'b0)) u_rst_kn (
    .clk_i     (k_clk_n_i),
    .reset_n_i (reset_n_i),
    .d_i       (1'b1),
    .q_o       (rst_kn_n)
  );

  // the mode pin is a static strap; a change while reading is not defined
  sbp_sync2 #(.W(1), .RST(1'b1)) u_mode (
    .clk_i     (k_clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (pll_disable_pin_i),
    .q_o       (long_q)
  );

  // ==========================================================================
  // true clock input registers

  logic              rd_req_q;
  logic [ADDR_W-1:0] raddr_q;
  logic              wsel_q;
  logic [WORD_W-1:0] w0_q;
  logic [LANES-1:0]  bw0_q;

  // read command and first write word share the true clock rise
  always_ff @(posedge k_clk_i or negedge rst_k_n) begin
    if (!rst_k_n) begin
      rd_req_q <= 1'b0;
      raddr_q  <= '0;
      wsel_q   <= 1'b0;
      w0_q     <= '0;
      bw0_q    <= '0;
    end else begin
      rd_req_q <= ~read_port_select_n_i;
      raddr_q  <= addr_i;
      wsel_q   <= ~write_port_select_n_i;
      w0_q     <= write_data_i;
      bw0_q    <= ~byte_lane_write_select_n_i;
    end
  end

  // ==========================================================================
  // complement clock input registers

  logic              wvalid_f_q;
  logic [ADDR_W-1:0] waddr_f_q;
  logic [WORD_W-1:0] w1_f_q;
  logic [LANES-1:0]  bw1_f_q;

  // write address and second word half a period after the select
  always_ff @(posedge k_clk_n_i or negedge rst_kn_n) begin
    if (!rst_kn_n) begin
      wvalid_f_q <= 1'b0;
      waddr_f_q  <= '0;
      w1_f_q     <= '0;
      bw1_f_q    <= '0;
    end else begin
      wvalid_f_q <= wsel_q;
      waddr_f_q  <= addr_i;
      w1_f_q     <= write_data_i;
      bw1_f_q    <= ~byte_lane_write_select_n_i;
    end
  end

  // ==========================================================================
  // array and pending write

  sbp_wreq_type wreq_c;
  sbp_pair_type mem_rd;
  sbp_pair_type look_c;
  logic         fwd_hit;

  // burst pair assembled from both clock phases
  assign wreq_c.addr    = waddr_f_q;
  assign wreq_c.data.w1 = w1_f_q;
  assign wreq_c.data.w0 = w0_q;
  assign wreq_c.lanes   = {bw1_f_q, bw0_q};

  // commit lands on the true clock rise after the pair is complete
  sbp_burst_mem u_mem (
    .clk_i   (k_clk_i),
    .we_i    (wvalid_f_q),
    .wreq_i  (wreq_c),
    .raddr_i (raddr_q),
    .rdata_o (mem_rd)
  );

  // a write committing on this edge is not yet in the array: forward it
  function automatic sbp_pair_type merge_pair(sbp_pair_type old_p,
                                              sbp_wreq_type w);
    logic [2*WORD_W-1:0] o;
    o = old_p;
    for (int l = 0; l < 2*LANES; l++) begin
      if (w.lanes[l]) begin
        o[l*LANE_W +: LANE_W] = w.data[l*LANE_W +: LANE_W];
      end
    end
    return o;
  endfunction

  assign fwd_hit = wvalid_f_q && (waddr_f_q == raddr_q);
  assign look_c  = fwd_hit ? merge_pair(mem_rd, wreq_c) : mem_rd;

  // ==========================================================================
  // read pipeline and output registers

  logic         p1_v_q;
  sbp_pair_type p1_pair_q;
  logic         valid_q;
  sbp_pair_type out_pair_q;
  logic         echo_q;
  logic         rd_tgl_q;
  logic         wr_tgl_q;

  // extra stage only used in the two-cycle mode
  always_ff @(posedge k_clk_i or negedge rst_k_n) begin
    if (!rst_k_n) begin
      p1_v_q    <= 1'b0;
      p1_pair_q <= '0;
    end else begin
      p1_v_q    <= rd_req_q;
      p1_pair_q <= look_c;
    end
  end

  // latency select; the write path never waits on this
  always_ff @(posedge k_clk_i or negedge rst_k_n) begin
    if (!rst_k_n) begin
      valid_q    <= 1'b0;
      out_pair_q <= '0;
    end else if (long_q) begin
      valid_q    <= p1_v_q;
      out_pair_q <= p1_pair_q;
    end else begin
      valid_q    <= rd_req_q;
      out_pair_q <= look_c;
    end
  end

  // true echo strobe toggles with each first word launch
  always_ff @(posedge k_clk_i or negedge rst_k_n) begin
    if (!rst_k_n) begin
      echo_q <= ECHO_RST;
    end else begin
      echo_q <= ~echo_q;
    end
  end

  // activity toggles for the core domain; toggles survive only a link clock several times slower than clk_i
  always_ff @(posedge k_clk_i or negedge rst_k_n) begin
    if (!rst_k_n) begin
      rd_tgl_q <= 1'b0;
      wr_tgl_q <= 1'b0;
    end else begin
      rd_tgl_q <= rd_tgl_q ^ rd_req_q;
      wr_tgl_q <= wr_tgl_q ^ wvalid_f_q;
    end
  end

  // second word leaves half a period later from its own register
  logic [WORD_W-1:0] fall_q;
  logic              echo_n_q;

  always_ff @(posedge k_clk_n_i or negedge rst_kn_n) begin
    if (!rst_kn_n) begin
      fall_q   <= '0;
      echo_n_q <= ECHO_N_RST;
    end else begin
      fall_q   <= out_pair_q.w1;
      echo_n_q <= ~echo_n_q;
    end
  end

  assign read_data_rise_o  = out_pair_q.w0;
  assign read_data_fall_o  = fall_q;
  assign read_valid_flag_o = valid_q;
  assign echo_strobe_o     = echo_q;
  assign echo_strobe_n_o   = echo_n_q;

  // ==========================================================================
  // core domain activity report

  logic [1:0] tgl_s;
  logic [1:0] tgl_prev_q;
  logic       rd_evt_q;
  logic       wr_evt_q;

  sbp_sync2 #(.W(2), .RST(2'h0)) u_tgl (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({wr_tgl_q, rd_tgl_q}),
    .q_o       (tgl_s)
  );

  // one pulse per link access; the link must run several times slower than us
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tgl_prev_q <= 2'h0;
      rd_evt_q   <= 1'b0;
      wr_evt_q   <= 1'b0;
    end else begin
      tgl_prev_q <= tgl_s;
      rd_evt_q   <= tgl_s[0] ^ tgl_prev_q[0];
      wr_evt_q   <= tgl_s[1] ^ tgl_prev_q[1];
    end
  end

  assign read_event_o  = rd_evt_q;
  assign write_event_o = wr_evt_q;

  // ==========================================================================
  // checks

  a_lat_two: assert property (
    @(posedge k_clk_i) disable iff (!rst_k_n)
    (rd_req_q && long_q) ##1 long_q |=> valid_q)
    else $error("two-cycle read did not return");

  a_lat_one: assert property (
    @(posedge k_clk_i) disable iff (!rst_k_n)
    (rd_req_q && !long_q) |=> valid_q)
    else $error("one-cycle read did not return");

  a_idle_quiet: assert property (
    @(posedge k_clk_i) disable iff (!rst_k_n)
    (!rd_req_q && !long_q) |=> !valid_q)
    else $error("valid flag without a read");

  a_fwd_fresh: assert property (
    @(posedge k_clk_i) disable iff (!rst_k_n)
    (rd_req_q && !long_q && fwd_hit && (&wreq_c.lanes))
      |=> out_pair_q == $past(wreq_c.data))
    else $error("read missed the newest write");

  a_concurrent: assert property (
    @(posedge k_clk_i) disable iff (!rst_k_n)
    (rd_req_q && wvalid_f_q && !long_q)
      |=> valid_q && (wr_tgl_q != $past(wr_tgl_q)))
    else $error("read and write did not both proceed");

  a_echo_run: assert property (
    @(posedge k_clk_i) disable iff (!rst_k_n)
    $past(rst_k_n) |-> echo_q != $past(echo_q))
    else $error("echo strobe stopped");

  a_wr_select: assert property (
    @(posedge k_clk_n_i) disable iff (!rst_kn_n)
    wsel_q |=> wvalid_f_q)
    else $error("write select not carried to the write phase");

  a_fall_word: assert property (
    @(posedge k_clk_n_i) disable iff (!rst_kn_n)
    valid_q |=> fall_q == $past(out_pair_q.w1))
    else $error("second word not launched");

  a_evt_pulse: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    rd_evt_q |=> !rd_evt_q)
    else $error("read event longer than one cycle");

endmodule // sbp_sram_port

//--- logic/sbp_pkg.sv
/*
  Shared constants and carrier types for the separate-port burst memory.
  Assumes the narrow (18-bit word) organisation with a reduced array depth.
*/
package sbp_pkg;

  // ==========================================================================
  // organisation
  localparam int WORD_W      = 18;            // narrow variant word
  localparam int WIDE_WORD_W = 36;            // wide variant word, not built
  localparam int LANE_W      = 9;
  localparam int LANES       = WORD_W / LANE_W;
  localparam int ADDR_W      = 8;
  localparam int DEPTH       = 1 << ADDR_W;

  // ==========================================================================
  // read latency in link clock cycles, selected by the mode pin
  localparam int LAT_PLL_ON  = 2;
  localparam int LAT_PLL_OFF = 1;

  // ==========================================================================
  // rates: link clock ceiling and resulting transfer rate per port
  localparam int K_MAX_MHZ    = 333;
  localparam int XFER_MAX_MHZ = 666;
  localparam int CLK_MHZ      = 100;

  // ==========================================================================
  // reset values
  localparam logic ECHO_RST   = 1'b0;
  localparam logic ECHO_N_RST = 1'b1;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic [WORD_W-1:0] w1;
    logic [WORD_W-1:0] w0;
  } sbp_pair_type;

  typedef struct packed {
    logic [ADDR_W-1:0]    addr;
    sbp_pair_type         data;
    logic [2*LANES-1:0]   lanes;
  } sbp_wreq_type;

endpackage

//--- logic/sbp_sync2.sv
/*
  Two-flop level synchroniser of parameterised width and reset value.
  Assumes its input is a level that stays put for several destination edges.
*/
module sbp_sync2 #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  // level in and out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // ==========================================================================
  // first stage feeds the second only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= RST;
      q_o    <= RST;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule // sbp_sync2

//--- logic/sbp_burst_mem.sv
/*
  Storage array of word pairs with per-lane write and combinational read.
  Assumes write requests arrive on the link clock already complete.
*/
module sbp_burst_mem
  import sbp_pkg::*;
(
  // clock
  input  wire logic              clk_i,
  // write side
  input  wire logic              we_i,
  input  wire sbp_wreq_type      wreq_i,
  // read side
  input  wire logic [ADDR_W-1:0] raddr_i,
  output sbp_pair_type           rdata_o
);

  logic [2*WORD_W-1:0] mem [DEPTH];

  // ==========================================================================
  // commit clocked on clk_i, lane by lane; no reset, content is undefined at start
  always_ff @(posedge clk_i) begin
    for (int l = 0; l < 2*LANES; l++) begin
      if (we_i && wreq_i.lanes[l]) begin
        mem[wreq_i.addr][l*LANE_W +: LANE_W] <=
          wreq_i.data[l*LANE_W +: LANE_W];
      end
    end
  end

  assign rdata_o = mem[raddr_i];

endmodule // sbp_burst_mem

//--- test/sbp_host_model.sv
/*
  Host controller model: makes the link clock pair and drives address,
  selects, lane enables and write data, one link cycle per call.
  Assumes the device samples on rising edges of both link clocks.
*/
module sbp_host_model
  import sbp_pkg::*;
(
  // link clocks
  output logic              k_clk_o,
  output logic              k_clk_n_o,
  // request pins
  output logic [ADDR_W-1:0] addr_o,
  output logic              read_port_select_n_o,
  output logic              write_port_select_n_o,
  output logic [LANES-1:0]  lanes_n_o,
  output logic [WORD_W-1:0] write_data_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // link clock: free running, odd offset keeps it apart from clk_i
  initial begin
    k_clk_o = 1'b0;
    #7.3;
    forever #32 k_clk_o = ~k_clk_o;
  end
  assign k_clk_n_o = ~k_clk_o;

  // idle pins at time zero
  initial begin
    addr_o                = '0;
    read_port_select_n_o  = 1'b1;
    write_port_select_n_o = 1'b1;
    lanes_n_o             = '1;
    write_data_o          = '0;
  end

  // ==========================================================================
  // one link cycle: read address and word0 before k rise, write address
  // and word1 before k_n rise; unused address and data lines get the inverse, never a hold
  task automatic cycle(input logic rd, input logic [ADDR_W-1:0] ra,
                       input logic wr, input logic [ADDR_W-1:0] wa,
                       input sbp_pair_type d,
                       input logic [2*LANES-1:0] ln_n);
    @(posedge k_clk_n_o);
    addr_o                <= rd ? ra : ~addr_o;
    read_port_select_n_o  <= ~rd;
    write_port_select_n_o <= ~wr;
    write_data_o          <= wr ? d.w0 : ~write_data_o;
    lanes_n_o             <= ln_n[LANES-1:0];
    @(posedge k_clk_o);
    addr_o                <= wr ? wa : ~addr_o;
    read_port_select_n_o  <= 1'b1;
    write_port_select_n_o <= 1'b1;
    write_data_o          <= wr ? d.w1 : ~write_data_o;
    lanes_n_o             <= ln_n[2*LANES-1:LANES];
  endtask
endmodule // sbp_host_model

//--- test/tb_top.sv
/*
  Self-checking bench of the burst memory port, both latency modes.
  Assumes sbp_host_model drives the link side; clk_i runs at 100 MHz.
*/
module tb_top
  import sbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // signals
  logic                   clk_i;
  logic                   reset_n_i;
  logic                   pin;
  logic                   k_clk;
  logic                   k_clk_n;
  logic [ADDR_W-1:0]      addr;
  logic                   rd_sel_n;
  logic                   wr_sel_n;
  logic [LANES-1:0]       lanes_n;
  logic [WORD_W-1:0]      wdata;
  logic [WORD_W-1:0]      rise;
  logic [WORD_W-1:0]      fall;
  logic                   valid;
  logic                   echo;
  logic                   echo_n;
  logic                   rev;
  logic                   wev;
  int                     fail_count;
  int                     checked;
  int                     kcnt;
  int                     rd_ev;
  int                     wr_ev;
  int                     n_rd;
  int                     n_wr;
  logic                   run;
  logic                   fall_pend;
  logic                   eprev;
  logic                   enprev;
  logic [WORD_W-1:0]      fall_exp;
  sbp_pair_type           mem [DEPTH];
  sbp_pair_type           exp_q [$];
  int                     at_q [$];

  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;

  sbp_host_model i_host (
    .k_clk_o               (k_clk),
    .k_clk_n_o             (k_clk_n),
    .addr_o                (addr),
    .read_port_select_n_o  (rd_sel_n),
    .write_port_select_n_o (wr_sel_n),
    .lanes_n_o             (lanes_n),
    .write_data_o          (wdata)
  );

  sbp_sram_port i_dut (
    .clk_i                      (clk_i),
    .reset_n_i                  (reset_n_i),
    .k_clk_i                    (k_clk),
    .k_clk_n_i                  (k_clk_n),
    .addr_i                     (addr),
    .read_port_select_n_i       (rd_sel_n),
    .write_port_select_n_i      (wr_sel_n),
    .byte_lane_write_select_n_i (lanes_n),
    .write_data_i               (wdata),
    .pll_disable_pin_i          (pin),
    .read_data_rise_o           (rise),
    .read_data_fall_o           (fall),
    .read_valid_flag_o          (valid),
    .echo_strobe_o              (echo),
    .echo_strobe_n_o            (echo_n),
    .read_event_o               (rev),
    .write_event_o              (wev)
  );

  // ==========================================================================
  // reporting
  task automatic check(input string what, input logic [2*WORD_W-1:0] seen,
                       input logic [2*WORD_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // read return monitor: valid must rise exactly L link cycles after take
  always @(posedge k_clk) kcnt <= kcnt + 1;
  always @(posedge k_clk) begin
    logic ev;
    sbp_pair_type cur;
    #1;
    if (run) begin
      check("echo_strobe", echo, !eprev);
      eprev = echo;
      ev = exp_q.size() > 0 &&
           kcnt - at_q[0] == (pin ? LAT_PLL_ON : LAT_PLL_OFF);
      check("read_valid_flag", valid, ev);
      if (ev) begin
        cur = exp_q.pop_front();
        at_q.delete(0);
        check("word0", rise, cur.w0);
        fall_exp = cur.w1;
        fall_pend = 1'b1;
      end
    end
  end
  // second word half a period later on the complement clock
  always @(posedge k_clk_n) begin
    #1;
    if (run) begin
      check("echo_strobe_n", echo_n, !enprev);
      enprev = echo_n;
      if (fall_pend) check("word1", fall, fall_exp);
      fall_pend = 1'b0;
    end
  end
  // core side pulses, counted per cycle high
  always @(posedge clk_i) begin
    if (rev === 1'b1) rd_ev++;
    if (wev === 1'b1) wr_ev++;
  end

  // ==========================================================================
  // one link cycle; a read sees the write taken at the same edge, since
  // the pending pair is forwarded before it reaches the array
  task automatic op(input logic rd, input logic [ADDR_W-1:0] ra,
                    input logic wr, input logic [ADDR_W-1:0] wa,
                    input sbp_pair_type d, input logic [2*LANES-1:0] ln_n);
    i_host.cycle(rd, ra, wr, wa, d, ln_n);
    #1;
    for (int i = 0; i < LANES; i++) begin
      if (wr && !ln_n[i]) mem[wa].w0[i*LANE_W +: LANE_W] =
        d.w0[i*LANE_W +: LANE_W];
      if (wr && !ln_n[LANES+i]) mem[wa].w1[i*LANE_W +: LANE_W] =
        d.w1[i*LANE_W +: LANE_W];
    end
    if (wr) n_wr++;
    if (rd) begin
      exp_q.push_back(mem[ra]);
      at_q.push_back(kcnt);
      n_rd++;
    end
  endtask

  task automatic settle();
    repeat (4) @(posedge k_clk);
    #3;
    check("reads pending", exp_q.size(), 0);
  endtask

  // ==========================================================================
  // reset with a mode; hold spans 8 link cycles so every domain sees it
  task automatic do_reset(input logic mode);
    run = 1'b0;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    pin       <= mode;
    repeat (3) @(posedge k_clk);
    #1;
    check("reset valid", valid, 1'b0);
    check("reset echo", {echo, echo_n}, {ECHO_RST, ECHO_N_RST});
    check("reset data", {rise, fall}, '0);
    repeat (5) @(posedge k_clk);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (5) @(posedge k_clk);
    #2;
    eprev     = echo;
    enprev    = echo_n;
    fall_pend = 1'b0;
    run       = 1'b1;
  endtask

  // write one pair then read it back
  task automatic t_basic();
    op(0, '0, 1, 8'h10, {18'h2aaaa, 18'h15555} ^ {36{pin}}, '0);
    op(1, 8'h10, 0, '0, '0, '1);
    settle();
  endtask

  // masked lanes keep old content
  task automatic t_lanes();
    op(0, '0, 1, 8'h20, {36{~pin}}, '0);
    op(0, '0, 1, 8'h20, {18'h0a5a5, 18'h35a5a}, 4'b0110);
    op(1, 8'h20, 0, '0, '0, '1);
    settle();
  endtask

  // back to back reads and writes together, newest data returned
  task automatic t_b2b();
    op(0, '0, 1, 8'h30, {18'h11111, 18'h22222} ^ {36{pin}}, '0);
    op(1, 8'h30, 1, 8'h31, {18'h33333, 18'h04444}, '0);
    op(1, 8'h31, 1, 8'h30, {18'h05555, 18'h36666}, '0);
    op(1, 8'h30, 0, '0, '0, '1);
    settle();
  endtask

  // read and write of one address at one edge: pending pair forwarded
  task automatic t_fwd();
    op(0, '0, 1, 8'h40, {18'h01234, 18'h3fedc} ^ {36{pin}}, '0);
    op(1, 8'h40, 1, 8'h40, {18'h2468a, 18'h13579}, '0);
    op(1, 8'h40, 1, 8'h40, {18'h0f0f0, 18'h30f0f}, 4'b1010);
    op(1, 8'h40, 0, '0, '0, '1);
    settle();
  endtask

  // ==========================================================================
  // main sequence: two-cycle mode, then one-cycle mode
  initial begin
    reset_n_i  = 1'b1; // first reset then starts on a clean falling edge
    pin        = 1'b1;
    fail_count = 0;
    checked    = 0;
    kcnt       = 0;
    {rd_ev, wr_ev, n_rd, n_wr} = '0;
    run        = 1'b0;
    fall_pend  = 1'b0;
    for (int m = 1; m >= 0; m--) begin
      do_reset(m[0]);
      t_basic();
      t_lanes();
      t_b2b();
      t_fwd();
      repeat (10) @(posedge clk_i);
      #1;
      check("read events", rd_ev, n_rd);
      check("write events", wr_ev, n_wr);
    end
    end_sim();
  end

  // watchdog, far beyond the few microseconds the run needs
  initial begin
    #50000;
    fail_count++;
    end_sim();
  end
endmodule // tb_top
